// >>> hdl/out_commit_pkg.sv
// constants and types shared by the out packet commit path
package out_commit_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PTR_W = 2;
    localparam int LEN_W = 11;
    localparam int MAX_BUFS = 4;
    localparam int MEM_AW = 12;
    localparam int FIFO_W = 10;
    localparam int FIFO_DEPTH = 32;
    // register offsets
    localparam logic [7:0] OFS_PKT_END = 8'h00;
    localparam logic [7:0] OFS_EP_CFG = 8'h01;
    localparam logic [7:0] OFS_FIFO_CFG = 8'h02;
    localparam logic [7:0] OFS_FIFO_RST = 8'h03;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_BC_HIGH = 8'h05;
    localparam logic [7:0] OFS_BC_LOW = 8'h06;
    localparam logic [7:0] OFS_BUF_DATA = 8'h07;
    localparam logic [7:0] OFS_BUF_PTR_LO = 8'h08;
    localparam logic [7:0] OFS_BUF_PTR_HI = 8'h09;
    localparam logic [7:0] OFS_TRIGGER = 8'h0A;
    // field positions
    localparam int SKIP_BIT = 7;
    localparam int NAK_ALL_BIT = 7;
    localparam int CFG_VALID_BIT = 7;
    localparam int CFG_DIR_BIT = 6;
    localparam int CFG_SIZE_BIT = 3;
    localparam int AUTO_OUT_BIT = 4;
    localparam int AUTO_IN_BIT = 3;
    localparam int ZERO_LEN_BIT = 2;
    localparam int WIDE_BIT = 0;
    localparam int EMPTY_FLAG_BIT = 1;
    localparam int FULL_FLAG_BIT = 0;
    localparam int TRIG_DONE_BIT = 7;
    localparam int TRIG_RW_BIT = 2;
    localparam int LAST_BIT = 8;
    localparam int GHOST_BIT = 9;
    // field codes
    localparam logic [3:0] EP_NUM_TWO = 4'h2;
    localparam logic [1:0] FIFO_SEL_TWO = 2'h0;
    localparam logic [1:0] BUF_QUAD = 2'h0;
    localparam logic [1:0] BUF_DOUBLE = 2'h2;
    localparam logic [1:0] BUF_TRIPLE = 2'h3;
    localparam logic [LEN_W-1:0] BUF_LEN_SMALL = 11'h200;
    localparam logic [LEN_W-1:0] BUF_LEN_LARGE = 11'h400;
    // reset values
    localparam logic [7:0] EP_CFG_RST = 8'hA2;
    localparam logic [7:0] FIFO_CFG_RST = 8'h00;
    typedef enum logic [1:0] {
        SLOT_CPU = 2'b00,
        SLOT_ARMED = 2'b01,
        SLOT_FULL = 2'b10,
        SLOT_COMMIT = 2'b11
    } slot_state_t;
endpackage

// >>> hdl/stream_if.sv
// valid/ready stream carrier between the block's own modules
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> hdl/stream_fifo.sv
// synchronous fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic flush_i,
    stream_if.snk push,
    stream_if.src pop
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push_fire = push.valid && push.ready;
    wire pop_fire = pop.valid && pop.ready;
    assign push.ready = (cnt_q != (AW+1)'(DEPTH)) && !flush_i;
    assign pop.valid = (cnt_q != '0) && !flush_i;
    assign pop.data = mem_q[rd_q];
    always_ff @(posedge clk_i) begin
        if (push_fire) begin
            mem_q[wr_q] <= push.data;
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i || flush_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push_fire) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop_fire) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push_fire) - (AW+1)'(pop_fire);
        end
    end
endmodule

// >>> hdl/buffer_slot.sv
// ownership state of one endpoint buffer
`timescale 1ns/1ps
module buffer_slot (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic release_i,
    input wire logic arm_i,
    input wire logic fill_i,
    input wire logic commit_i,
    output out_commit_pkg::slot_state_t state_o
);
    out_commit_pkg::slot_state_t st_q;
    assign state_o = st_q;
    always_ff @(posedge clk_i) begin
        if (srst_i || release_i) begin
            st_q <= out_commit_pkg::SLOT_CPU;
        end else if (arm_i) begin
            st_q <= out_commit_pkg::SLOT_ARMED;
        end else if (commit_i) begin
            st_q <= out_commit_pkg::SLOT_COMMIT;
        end else if (fill_i) begin
            st_q <= out_commit_pkg::SLOT_FULL;
        end
    end
endmodule

// >>> hdl/out_packet_commit_path.sv
// endpoint two out packet buffers, commit/skip control and interface fifo
//
// What this block does
// - auto commit on: each received packet goes to the fifo without firmware.
// - packet end write, skip clear, endpoint two: commit current buffer to master.
// - packet end write with skip set discards the current buffer.
// - firmware fills buffer, writes length high then low; low write commits.
// - buffer re-arms once all its data has left toward the master.
// - a skipped packet gives the master no sign at all.
// - after reset all buffers are unarmed; host packets are refused.
// - fifo reset 0x80 starts nak-all, 0x00 ends it.
// - fifo reset 0x82 during nak-all returns all endpoint two buffers to cpu.
// - packets leave strictly in order; commit/skip act on oldest buffer.
// - endpoint config 0xA2: out, bulk, 512 bytes, double buffered.
// - fifo config 0x10 sets auto commit only; 0x00 clears all four bits.
// - flags bit 0x02 is empty flag, zero once a packet is held.
// - manual mode: byte count low bit 7 set skips, clear commits.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module out_packet_commit_path #(
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic usb_valid_i,
    input wire logic [7:0] usb_data_i,
    input wire logic usb_last_i,
    output logic usb_ready_o,
    output logic usb_nak_o,
    output logic mst_valid_o,
    output logic [7:0] mst_data_o,
    output logic mst_last_o,
    input wire logic mst_ready_i
);
    localparam int PW = out_commit_pkg::PTR_W;
    localparam int LW = out_commit_pkg::LEN_W;
    localparam int NB = out_commit_pkg::MAX_BUFS;
    localparam int FW = out_commit_pkg::FIFO_W;

    logic [7:0] ep_cfg_q;
    logic [7:0] fifo_cfg_q;
    logic nak_all_q;
    logic eng_run_q;
    logic [2:0] bch_q;
    logic [9:0] cpu_addr_q;
    logic [PW-1:0] fill_ptr_q;
    logic [PW-1:0] own_ptr_q;
    logic [PW-1:0] st_ptr_q;
    logic [PW-1:0] done_ptr_q;
    logic [LW-1:0] wr_cnt_q;
    logic [LW-1:0] st_cnt_q;
    logic [2:0] inflight_q;
    logic [LW-1:0] len_q [NB];
    logic [7:0] mem_q [2**out_commit_pkg::MEM_AW];
    logic [7:0] rdata_q;
    out_commit_pkg::slot_state_t slot_st [NB];
    logic [NB-1:0] busy_vec;
    logic [NB-1:0] armed_vec;
    logic [NB-1:0] commit_vec;

    stream_if #(.W(FW)) push_s ();
    stream_if #(.W(FW)) pop_s ();

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p, input logic [2:0] n);
        next_ptr = ({1'b0, p} == n - 3'd1) ? '0 : p + 1'b1;
    endfunction

    // register decode
    wire wr_pkt_end = reg_wr_i && (reg_addr_i == out_commit_pkg::OFS_PKT_END);
    wire wr_ep_cfg = reg_wr_i && (reg_addr_i == out_commit_pkg::OFS_EP_CFG);
    wire wr_fifo_cfg = reg_wr_i && (reg_addr_i == out_commit_pkg::OFS_FIFO_CFG);
    wire wr_fifo_rst = reg_wr_i && (reg_addr_i == out_commit_pkg::OFS_FIFO_RST);
    wire wr_bch = reg_wr_i && (reg_addr_i == out_commit_pkg::OFS_BC_HIGH);
    wire wr_bcl = reg_wr_i && (reg_addr_i == out_commit_pkg::OFS_BC_LOW);
    wire wr_buf = reg_wr_i && (reg_addr_i == out_commit_pkg::OFS_BUF_DATA);
    wire wr_ptr_lo = reg_wr_i && (reg_addr_i == out_commit_pkg::OFS_BUF_PTR_LO);
    wire wr_ptr_hi = reg_wr_i && (reg_addr_i == out_commit_pkg::OFS_BUF_PTR_HI);
    wire wr_trig = reg_wr_i && (reg_addr_i == out_commit_pkg::OFS_TRIGGER);
    wire sel_ep_two = reg_wdata_i[3:0] == out_commit_pkg::EP_NUM_TWO;
    wire skip_bit = reg_wdata_i[out_commit_pkg::SKIP_BIT];

    // endpoint and fifo configuration fields
    wire ep_valid = ep_cfg_q[out_commit_pkg::CFG_VALID_BIT];
    wire ep_out = !ep_cfg_q[out_commit_pkg::CFG_DIR_BIT];
    wire [1:0] buf_code = ep_cfg_q[1:0];
    wire [2:0] nbuf = (buf_code == out_commit_pkg::BUF_QUAD) ? 3'd4 :
                      (buf_code == out_commit_pkg::BUF_TRIPLE) ? 3'd3 : 3'd2;
    wire [LW-1:0] max_len = ep_cfg_q[out_commit_pkg::CFG_SIZE_BIT] ?
                            out_commit_pkg::BUF_LEN_LARGE : out_commit_pkg::BUF_LEN_SMALL;
    wire auto_out = fifo_cfg_q[out_commit_pkg::AUTO_OUT_BIT];

    // oldest buffer on the firmware side
    out_commit_pkg::slot_state_t own_st;
    assign own_st = slot_st[own_ptr_q];
    wire own_full = own_st == out_commit_pkg::SLOT_FULL;
    wire own_held = own_full || (own_st == out_commit_pkg::SLOT_CPU);

    // endpoint reset only while nak-all stands
    wire ep_rst = wr_fifo_rst && nak_all_q && reg_wdata_i[out_commit_pkg::NAK_ALL_BIT] &&
                  sel_ep_two;

    wire man_skip = wr_pkt_end && sel_ep_two && skip_bit && own_held;
    wire man_commit = wr_pkt_end && sel_ep_two && !skip_bit && !auto_out && own_full;
    wire bcl_act = wr_bcl && !auto_out && own_held;
    wire src_skip = bcl_act && skip_bit;
    wire src_commit = bcl_act && !skip_bit;
    wire auto_arm = auto_out && (own_st == out_commit_pkg::SLOT_CPU);
    wire auto_commit = auto_out && own_full;
    // skips and arms pass the streamer as empty entries so the ring stays in order
    wire own_to_armed = (man_skip || src_skip || auto_arm) && !ep_rst;
    wire own_to_commit = (man_commit || src_commit || auto_commit) && !own_to_armed && !ep_rst;
    wire own_adv = own_to_armed || own_to_commit;

    // host side of the endpoint
    wire fill_armed = slot_st[fill_ptr_q] == out_commit_pkg::SLOT_ARMED;
    assign usb_ready_o = ep_valid && ep_out && !nak_all_q && fill_armed && !ep_rst;
    assign usb_nak_o = !usb_ready_o;
    wire usb_fire = usb_valid_i && usb_ready_o;
    wire fill_done = usb_fire && usb_last_i;
    wire wr_room = wr_cnt_q < max_len;
    wire [LW-1:0] fill_len = wr_room ? wr_cnt_q + 1'b1 : max_len;

    // streamer from committed buffers into the interface fifo
    out_commit_pkg::slot_state_t st_st;
    assign st_st = slot_st[st_ptr_q];
    wire [LW-1:0] st_len = len_q[st_ptr_q];
    wire st_ghost = st_len == '0;
    wire st_last = st_ghost || (st_cnt_q == st_len - 1'b1);
    wire can_stream = (st_st == out_commit_pkg::SLOT_COMMIT) &&
                      ((st_ptr_q != done_ptr_q) || (inflight_q == '0)) && !ep_rst;
    assign push_s.valid = can_stream;
    assign push_s.data = {st_ghost, st_last, mem_q[{st_ptr_q, st_cnt_q[9:0]}]};
    wire push_fire = push_s.valid && push_s.ready;
    wire pkt_pushed = push_fire && st_last;

    // master side; ghost entries of empty packets are dropped unseen
    wire pop_ghost = pop_s.data[out_commit_pkg::GHOST_BIT];
    assign mst_valid_o = pop_s.valid && !pop_ghost && eng_run_q;
    assign mst_data_o = pop_s.data[7:0];
    assign mst_last_o = pop_s.data[out_commit_pkg::LAST_BIT];
    assign pop_s.ready = (mst_ready_i && eng_run_q) || pop_ghost;
    wire pop_fire = pop_s.valid && pop_s.ready;
    wire rearm = pop_fire && pop_s.data[out_commit_pkg::LAST_BIT];

    stream_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .flush_i(ep_rst),
        .push(push_s),
        .pop(pop_s)
    );

    for (genvar i = 0; i < NB; i++) begin : g_slot
        buffer_slot u_slot (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .release_i(ep_rst),
            .arm_i(rearm && done_ptr_q == PW'(i)),
            .fill_i(fill_done && fill_ptr_q == PW'(i)),
            .commit_i(own_adv && own_ptr_q == PW'(i)),
            .state_o(slot_st[i])
        );
        assign busy_vec[i] = (slot_st[i] == out_commit_pkg::SLOT_FULL) ||
                             (slot_st[i] == out_commit_pkg::SLOT_COMMIT);
        assign armed_vec[i] = slot_st[i] == out_commit_pkg::SLOT_ARMED;
        assign commit_vec[i] = slot_st[i] == out_commit_pkg::SLOT_COMMIT;
    end

    // read side of the register port
    wire fifo_idle = !pop_s.valid && (inflight_q == '0);
    wire [7:0] flags_val = {6'h00, ~|busy_vec, ~|armed_vec};
    wire [7:0] trig_val = {~|commit_vec && fifo_idle, 7'h00};
    wire [LW-1:0] own_len = len_q[own_ptr_q];
    wire [7:0] rd_val =
        (reg_addr_i == out_commit_pkg::OFS_EP_CFG) ? ep_cfg_q :
        (reg_addr_i == out_commit_pkg::OFS_FIFO_CFG) ? fifo_cfg_q :
        (reg_addr_i == out_commit_pkg::OFS_FIFO_RST) ? {nak_all_q, 7'h00} :
        (reg_addr_i == out_commit_pkg::OFS_FLAGS) ? flags_val :
        (reg_addr_i == out_commit_pkg::OFS_BC_HIGH) ? {5'h00, own_len[10:8]} :
        (reg_addr_i == out_commit_pkg::OFS_BC_LOW) ? own_len[7:0] :
        (reg_addr_i == out_commit_pkg::OFS_BUF_PTR_LO) ? cpu_addr_q[7:0] :
        (reg_addr_i == out_commit_pkg::OFS_BUF_PTR_HI) ? {6'h00, cpu_addr_q[9:8]} :
        (reg_addr_i == out_commit_pkg::OFS_TRIGGER) ? trig_val : 8'h00;
    assign reg_rdata_o = rdata_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd_i ? rd_val : 8'h00;
        end
    end

    // configuration and control registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ep_cfg_q <= out_commit_pkg::EP_CFG_RST;
            fifo_cfg_q <= out_commit_pkg::FIFO_CFG_RST;
            nak_all_q <= 1'b0;
            eng_run_q <= 1'b0;
            bch_q <= 3'h0;
            cpu_addr_q <= 10'h000;
        end else begin
            if (wr_ep_cfg) begin
                ep_cfg_q <= reg_wdata_i;
            end
            if (wr_fifo_cfg) begin
                fifo_cfg_q <= reg_wdata_i & 8'h1D;
            end
            if (wr_fifo_rst) begin
                nak_all_q <= reg_wdata_i[out_commit_pkg::NAK_ALL_BIT];
            end
            if (ep_rst) begin
                eng_run_q <= 1'b0;
            end else if (wr_trig && !reg_wdata_i[out_commit_pkg::TRIG_RW_BIT] &&
                         reg_wdata_i[1:0] == out_commit_pkg::FIFO_SEL_TWO) begin
                eng_run_q <= 1'b1;
            end
            if (wr_bch) begin
                bch_q <= reg_wdata_i[2:0];
            end
            if (wr_ptr_lo) begin
                cpu_addr_q[7:0] <= reg_wdata_i;
            end else if (wr_ptr_hi) begin
                cpu_addr_q[9:8] <= reg_wdata_i[1:0];
            end else if (wr_buf && own_held) begin
                cpu_addr_q <= cpu_addr_q + 10'h001;
            end
        end
    end

    // buffer memory: host fill port and firmware edit port hit different slots
    always_ff @(posedge clk_i) begin
        if (usb_fire && wr_room) begin
            mem_q[{fill_ptr_q, wr_cnt_q[9:0]}] <= usb_data_i;
        end
        if (wr_buf && own_held) begin
            mem_q[{own_ptr_q, cpu_addr_q}] <= reg_wdata_i;
        end
    end

    // packet lengths
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < NB; i++) begin
                len_q[i] <= '0;
            end
        end else begin
            if (fill_done) begin
                len_q[fill_ptr_q] <= fill_len;
            end
            if (own_to_armed) begin
                len_q[own_ptr_q] <= '0;
            end
            if (own_to_commit && src_commit) begin
                len_q[own_ptr_q] <= {bch_q, reg_wdata_i};
            end
        end
    end

    // ring pointers and counters
    always_ff @(posedge clk_i) begin
        if (srst_i || ep_rst) begin
            fill_ptr_q <= '0;
            own_ptr_q <= '0;
            st_ptr_q <= '0;
            done_ptr_q <= '0;
            wr_cnt_q <= '0;
            st_cnt_q <= '0;
            inflight_q <= 3'h0;
        end else begin
            if (fill_done) begin
                fill_ptr_q <= next_ptr(fill_ptr_q, nbuf);
                wr_cnt_q <= '0;
            end else if (usb_fire && wr_room) begin
                wr_cnt_q <= wr_cnt_q + 1'b1;
            end
            if (own_adv) begin
                own_ptr_q <= next_ptr(own_ptr_q, nbuf);
            end
            if (pkt_pushed) begin
                st_ptr_q <= next_ptr(st_ptr_q, nbuf);
                st_cnt_q <= '0;
            end else if (push_fire) begin
                st_cnt_q <= st_cnt_q + 1'b1;
            end
            if (rearm) begin
                done_ptr_q <= next_ptr(done_ptr_q, nbuf);
            end
            inflight_q <= inflight_q + 3'(pkt_pushed) - 3'(rearm);
        end
    end
endmodule

// >>> sim/out_commit_asserts.sv
// port-level concurrent checks for the out packet commit path
`timescale 1ns/1ps
module out_commit_asserts #(
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic usb_valid_i,
    input wire logic [7:0] usb_data_i,
    input wire logic usb_last_i,
    input wire logic usb_ready_o,
    input wire logic usb_nak_o,
    input wire logic mst_valid_o,
    input wire logic [7:0] mst_data_o,
    input wire logic mst_last_o,
    input wire logic mst_ready_i
);
    logic nak_q;
    logic auto_q;
    wire logic rst_wr;
    wire logic end_wr;
    wire logic bcl_wr;
    wire logic cfg_wr;
    assign rst_wr = reg_wr_i && reg_addr_i == out_commit_pkg::OFS_FIFO_RST;
    assign end_wr = reg_wr_i && reg_addr_i == out_commit_pkg::OFS_PKT_END;
    assign bcl_wr = reg_wr_i && reg_addr_i == out_commit_pkg::OFS_BC_LOW;
    assign cfg_wr = reg_wr_i && reg_addr_i == out_commit_pkg::OFS_FIFO_CFG;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            nak_q <= 1'b0;
            auto_q <= 1'b0;
        end else begin
            nak_q <= rst_wr ? reg_wdata_i[7] : nak_q;
            auto_q <= cfg_wr ? reg_wdata_i[out_commit_pkg::AUTO_OUT_BIT] : auto_q;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    a_nak_inverse: assert property (usb_nak_o == !usb_ready_o)
        else $error("nak is not the inverse of ready");
    a_reset_unarmed: assert property ($fell(srst_i) |-> usb_nak_o && !mst_valid_o)
        else $error("buffers armed right after reset");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its cycle");
    a_nakall_holds: assert property ((rst_wr && reg_wdata_i == 8'h80) |=> usb_nak_o [*4])
        else $error("nak-all did not take hold");
    a_nak_while_set: assert property (nak_q |-> usb_nak_o)
        else $error("host accepted during nak-all");
    a_skip_silent: assert property ((end_wr && reg_wdata_i[7] && !mst_valid_o) |=> !mst_valid_o [*4])
        else $error("skipped packet reached the master");
    a_master_hold: assert property (mst_valid_o && !mst_ready_i |=> mst_valid_o && $stable(mst_data_o) && $stable(mst_last_o))
        else $error("master byte changed before taken");
    a_rearm_last: assert property (mst_valid_o && mst_ready_i && mst_last_o && !nak_q |-> ##[1:2] usb_ready_o)
        else $error("buffer not re-armed after drain");
    a_commit_soon: assert property (end_wr && !reg_wdata_i[7] && !auto_q |-> ##[2:3] mst_valid_o)
        else $error("commit did not reach master");
    a_source_soon: assert property (bcl_wr && !reg_wdata_i[7] && !auto_q |-> ##[2:3] mst_valid_o)
        else $error("sourced packet did not reach master");
    a_auto_soon: assert property (usb_valid_i && usb_ready_o && usb_last_i && auto_q |-> ##[2:8] mst_valid_o)
        else $error("auto commit did not reach master");
endmodule
bind out_packet_commit_path out_commit_asserts #(.DEPTH(DEPTH)) u_chk (
    .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .usb_valid_i(usb_valid_i), .usb_data_i(usb_data_i), .usb_last_i(usb_last_i),
    .usb_ready_o(usb_ready_o), .usb_nak_o(usb_nak_o), .mst_valid_o(mst_valid_o),
    .mst_data_o(mst_data_o), .mst_last_o(mst_last_o), .mst_ready_i(mst_ready_i));

// >>> sim/master_model.sv
// far-side master draining the interface fifo
`timescale 1ns/1ps
module master_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    input wire logic last_i,
    input wire logic stall_i,
    input wire logic slow_i,
    output logic ready_o
);
    logic phase_q = 1'b0;
    logic [8:0] got[$];
    initial ready_o = 1'b0;
    always @(posedge clk_i) begin
        if (srst_i) begin
            ready_o <= 1'b0;
            phase_q <= 1'b0;
        end else begin
            phase_q <= !phase_q;
            ready_o <= !stall_i && (!slow_i || phase_q);
            if (valid_i && ready_o) begin
                got.push_back({last_i, data_i});
            end
        end
    end
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the out packet commit path
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic usb_valid_i = 1'b0;
    logic [7:0] usb_data_i = 8'h00;
    logic usb_last_i = 1'b0;
    logic usb_ready_o;
    logic usb_nak_o;
    logic mst_valid_o;
    logic [7:0] mst_data_o;
    logic mst_last_o;
    logic mst_ready_i;
    logic stall = 1'b0;
    logic slow = 1'b0;
    int n_errors = 0;
    int checks = 0;
    always #50 clk_i = ~clk_i;
    out_packet_commit_path #(.DEPTH(32)) DUT (.clk_i(clk_i), .srst_i(srst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .usb_valid_i(usb_valid_i),
        .usb_data_i(usb_data_i), .usb_last_i(usb_last_i), .usb_ready_o(usb_ready_o),
        .usb_nak_o(usb_nak_o), .mst_valid_o(mst_valid_o), .mst_data_o(mst_data_o),
        .mst_last_o(mst_last_o), .mst_ready_i(mst_ready_i));
    master_model MST (.clk_i(clk_i), .srst_i(srst_i), .valid_i(mst_valid_o),
        .data_i(mst_data_o), .last_i(mst_last_o), .stall_i(stall), .slow_i(slow),
        .ready_o(mst_ready_i));
    task automatic results;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic hang;
        n_errors++;
        $display("Error wait expected done seen timeout");
        results();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK(n, e, reg_rdata_o)
    endtask
    task automatic send(input int n, input logic [7:0] b);
        int i;
        int k;
        for (i = 0; i < n; i++) begin
            usb_valid_i <= 1'b1;
            usb_data_i <= b + 8'(i);
            usb_last_i <= (i == n - 1);
            k = 0;
            do begin
                @(posedge clk_i);
                k++;
            end while (usb_ready_o !== 1'b1 && k < 300);
            if (k >= 300) hang();
        end
        usb_valid_i <= 1'b0;
        usb_last_i <= 1'b0;
        #1;
    endtask
    task automatic expect_pkt(input int n, input logic [7:0] b);
        int i;
        int k;
        logic [8:0] v;
        k = 0;
        while (MST.got.size() < n && k < 3000) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 3000) hang();
        for (i = 0; i < n; i++) begin
            v = MST.got.pop_front();
            `CHK("master byte", {i == n - 1, b + 8'(i)}, v)
        end
    endtask
    task automatic t_reset;
        `CHK("nak", 1'b1, usb_nak_o)
        rchk("flags", out_commit_pkg::OFS_FLAGS, 8'h03);
        rchk("ep cfg", out_commit_pkg::OFS_EP_CFG, 8'hA2);
        rchk("fifo cfg", out_commit_pkg::OFS_FIFO_CFG, 8'h00);
        rchk("unmapped", 8'hFF, 8'h00);
        wr(out_commit_pkg::OFS_EP_CFG, 8'hA2);
        rchk("ep cfg", out_commit_pkg::OFS_EP_CFG, 8'hA2);
        `CHK("ready", 1'b0, usb_ready_o)
        wr(out_commit_pkg::OFS_PKT_END, 8'h82);
        wr(out_commit_pkg::OFS_PKT_END, 8'h82);
        `CHK("armed", 1'b1, usb_ready_o)
        $display("test reset done");
    endtask
    task automatic t_manual;
        wr(out_commit_pkg::OFS_TRIGGER, 8'h00);
        send(4, 8'h10);
        send(3, 8'h20);
        `CHK("both full", 1'b0, usb_ready_o)
        rchk("flags", out_commit_pkg::OFS_FLAGS, 8'h01);
        wr(out_commit_pkg::OFS_PKT_END, 8'h02);
        expect_pkt(4, 8'h10);
        wr(out_commit_pkg::OFS_PKT_END, 8'h82);
        repeat (10) @(posedge clk_i);
        `CHK("skip silent", 0, MST.got.size())
        `CHK("rearmed", 1'b1, usb_ready_o)
        send(2, 8'h30);
        wr(out_commit_pkg::OFS_PKT_END, 8'h02);
        expect_pkt(2, 8'h30);
        rchk("flags", out_commit_pkg::OFS_FLAGS, 8'h02);
        rchk("done", out_commit_pkg::OFS_TRIGGER, 8'h80);
        $display("test manual done");
    endtask
    task automatic t_nak;
        int i;
        wr(out_commit_pkg::OFS_FIFO_RST, 8'h80);
        `CHK("nak all", 1'b1, usb_nak_o)
        wr(out_commit_pkg::OFS_FIFO_RST, 8'h82);
        rchk("flags", out_commit_pkg::OFS_FLAGS, 8'h03);
        wr(out_commit_pkg::OFS_TRIGGER, 8'h00);
        wr(out_commit_pkg::OFS_BUF_PTR_LO, 8'h00);
        wr(out_commit_pkg::OFS_BUF_PTR_HI, 8'h00);
        for (i = 0; i < 3; i++) wr(out_commit_pkg::OFS_BUF_DATA, 8'h41 + 8'(i));
        wr(out_commit_pkg::OFS_BC_HIGH, 8'h00);
        wr(out_commit_pkg::OFS_BC_LOW, 8'h03);
        expect_pkt(3, 8'h41);
        `CHK("nak held", 1'b1, usb_nak_o)
        wr(out_commit_pkg::OFS_BC_LOW, 8'h80);
        wr(out_commit_pkg::OFS_FIFO_RST, 8'h00);
        `CHK("released", 1'b1, usb_ready_o)
        `CHK("skip by count", 0, MST.got.size())
        $display("test nak done");
    endtask
    task automatic t_auto;
        wr(out_commit_pkg::OFS_FIFO_CFG, 8'h10);
        rchk("fifo cfg", out_commit_pkg::OFS_FIFO_CFG, 8'h10);
        stall <= 1'b1;
        send(40, 8'h60);
        repeat (60) @(posedge clk_i);
        stall <= 1'b0;
        slow <= 1'b1;
        expect_pkt(40, 8'h60);
        wr(out_commit_pkg::OFS_FIFO_CFG, 8'h00);
        rchk("fifo cfg", out_commit_pkg::OFS_FIFO_CFG, 8'h00);
        $display("test auto done");
    endtask
    task automatic t_reset2;
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        `CHK("nak again", 1'b1, usb_nak_o)
        `CHK("master idle", 1'b0, mst_valid_o)
        $display("test second reset done");
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_manual();
        t_nak();
        t_auto();
        t_reset2();
        results();
    end
endmodule
